/* File: bal_core.sv */
// Byte ALU datapath: add, and, shift and pointer-add execution
//
// Notes on behaviour
// - A taken branch or true test costs one more cycle, the last one idle.
// - An indirect-port file operand with pointer MSB set adds a cycle.
// - Pointer-add adds a sign-extended 6-bit literal, flags untouched.
// - Pointer sums wrap modulo 65536 within 0000h to FFFFh.
// - Immediate add sums accumulator and literal, sets C, nibble, Z.
// - File add sums accumulator and file 0..127, sets C, nibble, Z.
// - Destination 0 writes the accumulator, 1 writes the file back.
// - Add with carry sums accumulator, file and carry to the destination.
// - Immediate AND writes accumulator AND literal back, Z only.
// - File AND writes accumulator AND file to the destination, Z only.
// - Arithmetic shift right keeps bit 7, old bit 0 to C, C and Z only.
// - Pointer-add decodes as 1100010, select bit, six literal bits.
`timescale 1ns/1ps
module bal_core #(
  parameter int unsigned CYCLE_CLKS = bal_pkg::CYCLE_CLKS_DEF
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic INSTR_VALID_I,
  input wire logic [13:0] INSTR_I,
  input wire logic PROGRAM_COUNTER_CHANGE_I,
  input wire logic TEST_TRUE_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  output logic [7:0] ACC_O,
  output logic CARRY_O,
  output logic NIBBLE_OVERFLOW_FLAG_O,
  output logic ZERO_O,
  output logic [15:0] POINTER0_O,
  output logic [15:0] POINTER1_O,
  output logic READY_O,
  output logic IDLE_SLOT_O
);
  localparam int unsigned CW = bal_pkg::CNT_W;

  bal_fr_mem_if mem_if ();

  bal_fr_mem #(.DEPTH(bal_pkg::FILE_DEPTH)) u_mem (
    .clk_i(CORE_CLK_I),
    .port(mem_if.mem)
  );

  bal_pkg::bal_state_t state;
  bal_pkg::bal_state_t next_state;
  logic [7:0] acc;
  logic carry;
  logic nib;
  logic zero;
  logic [15:0] ptr [2];
  logic [13:0] ir;
  logic [6:0] ea;
  logic taken_q;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  // Decode of the incoming instruction, used at acceptance
  wire accept = INSTR_VALID_I && READY_O;
  wire [5:0] in_op = INSTR_I[13:8];
  wire [6:0] in_addr = INSTR_I[6:0];
  wire in_file = (in_op == bal_pkg::OP_ADD_FILE) ||
    (in_op == bal_pkg::OP_ADDC_FILE) || (in_op == bal_pkg::OP_AND_FILE) ||
    (in_op == bal_pkg::OP_ASR_FILE);
  wire in_ind = (in_addr == bal_pkg::IND_PORT0) ||
    (in_addr == bal_pkg::IND_PORT1);
  wire in_sel = in_addr[0];
  wire [15:0] in_ptr = in_sel ? ptr[1] : ptr[0];
  wire in_ind_ext = in_file && in_ind && in_ptr[15];
  wire in_taken = PROGRAM_COUNTER_CHANGE_I || TEST_TRUE_I;
  wire [1:0] in_cycles = 2'h1 + {1'b0, in_taken} + {1'b0, in_ind_ext};
  wire [CW-1:0] in_clks = CW'(in_cycles) * CW'(CYCLE_CLKS);
  wire [6:0] in_ea = in_ind ? in_ptr[6:0] : in_addr;

  // Decode of the held instruction, used in the execute clock
  wire exec = (state == bal_pkg::ST_EXEC);
  wire [5:0] op = ir[13:8];
  wire is_add_imm = (op == bal_pkg::OP_ADD_IMM);
  wire is_and_imm = (op == bal_pkg::OP_AND_IMM);
  wire is_add_file = (op == bal_pkg::OP_ADD_FILE);
  wire is_addc = (op == bal_pkg::OP_ADDC_FILE);
  wire is_and_file = (op == bal_pkg::OP_AND_FILE);
  wire is_asr = (op == bal_pkg::OP_ASR_FILE);
  wire is_ptr_add = (ir[13:7] == bal_pkg::OP_PTR_ADD);
  wire is_file = is_add_file || is_addc || is_and_file || is_asr;
  wire is_add_any = is_add_imm || is_add_file || is_addc;
  wire is_and_any = is_and_imm || is_and_file;
  wire dest = ir[bal_pkg::DEST_BIT];
  wire psel = ir[bal_pkg::PTR_SEL_BIT];
  wire [7:0] fval = mem_if.rd_data;
  wire [7:0] lit = ir[7:0];

  // Arithmetic and logic results
  wire [7:0] add_b = is_add_imm ? lit : fval;
  wire cin = is_addc && carry;
  wire [8:0] sum9 = {1'b0, acc} + {1'b0, add_b} + {8'h00, cin};
  wire [4:0] nib_sum = {1'b0, acc[3:0]} + {1'b0, add_b[3:0]} +
    {4'h0, cin};
  wire [7:0] and_res = acc & (is_and_imm ? lit : fval);
  wire [7:0] asr_res = {fval[7], fval[7:1]};
  wire [7:0] result = is_add_any ? sum9[7:0] :
    (is_and_any ? and_res : asr_res);
  wire [15:0] sext = {{(16 - bal_pkg::LIT_W){ir[bal_pkg::LIT_SIGN_BIT]}},
    ir[5:0]};
  // Plain 16-bit sum drops the carry, giving the wrap-around
  wire [15:0] ptr_sum = (psel ? ptr[1] : ptr[0]) + sext;

  // Destination and flag selection
  wire to_acc = exec && (is_add_imm || is_and_imm ||
    (is_file && !dest));
  wire to_file = exec && is_file && dest;
  wire upd_c = exec && (is_add_any || is_asr);
  wire upd_dc = exec && is_add_any;
  wire upd_z = exec && (is_add_any || is_and_any || is_asr);
  wire new_c = is_asr ? fval[0] : sum9[8];
  wire new_z = (result == 8'h00);
  wire ptr0_upd = exec && is_ptr_add && !psel;
  wire ptr1_upd = exec && is_ptr_add && psel;

  // Register bus decode
  wire wr_acc = WR_I && (ADDR_I == bal_pkg::REG_ACC);
  wire wr_st = WR_I && (ADDR_I == bal_pkg::REG_STATUS);
  wire wr_p0l = WR_I && (ADDR_I == bal_pkg::REG_PTR0_LO);
  wire wr_p0h = WR_I && (ADDR_I == bal_pkg::REG_PTR0_HI);
  wire wr_p1l = WR_I && (ADDR_I == bal_pkg::REG_PTR1_LO);
  wire wr_p1h = WR_I && (ADDR_I == bal_pkg::REG_PTR1_HI);
  wire [7:0] status_rd = {5'h00, zero, nib, carry};
  wire [7:0] core_rd = {6'h00, IDLE_SLOT_O, READY_O};
  wire [7:0] rd_mux =
    (ADDR_I == bal_pkg::REG_ACC) ? acc :
    (ADDR_I == bal_pkg::REG_STATUS) ? status_rd :
    (ADDR_I == bal_pkg::REG_PTR0_LO) ? ptr[0][7:0] :
    (ADDR_I == bal_pkg::REG_PTR0_HI) ? ptr[0][15:8] :
    (ADDR_I == bal_pkg::REG_PTR1_LO) ? ptr[1][7:0] :
    (ADDR_I == bal_pkg::REG_PTR1_HI) ? ptr[1][15:8] :
    (ADDR_I == bal_pkg::REG_CORE) ? core_rd : 8'h00;

  // Memory port: read is issued at acceptance, write in the execute clock
  assign mem_if.rd_addr = in_ea;
  assign mem_if.wr_en = to_file;
  assign mem_if.wr_addr = ea;
  assign mem_if.wr_data = result;

  // Sequencer; one instruction cycle spans CYCLE_CLKS clocks
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      bal_pkg::ST_READY:
      begin
        if (accept)
        begin
          next_state = bal_pkg::ST_EXEC;
          next_cnt = in_clks - CW'(1);
        end
      end
      bal_pkg::ST_EXEC, bal_pkg::ST_WAIT:
      begin
        if (cnt <= CW'(1))
        begin
          next_state = bal_pkg::ST_READY;
          next_cnt = '0;
        end
        else
        begin
          next_state = bal_pkg::ST_WAIT;
          next_cnt = cnt - CW'(1);
        end
      end
      default:
      begin
        next_state = bal_pkg::ST_READY;
        next_cnt = '0;
      end
    endcase
  end

  wire next_taken = accept ? in_taken : taken_q;
  // Idle slot covers the last instruction cycle of a taken instruction
  wire next_idle = next_taken && (next_cnt != '0) &&
    (next_cnt <= CW'(CYCLE_CLKS));

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      state <= bal_pkg::ST_READY;
      cnt <= '0;
      taken_q <= 1'b0;
      ir <= '0;
      ea <= '0;
      READY_O <= 1'b1;
      IDLE_SLOT_O <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      taken_q <= next_taken;
      READY_O <= (next_state == bal_pkg::ST_READY);
      IDLE_SLOT_O <= next_idle;
      if (accept)
      begin
        ir <= INSTR_I;
        ea <= in_ea;
      end
    end
  end

  // Accumulator and flags; the executing instruction wins over the bus
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      acc <= bal_pkg::ACC_RST;
      carry <= 1'b0;
      nib <= 1'b0;
      zero <= 1'b0;
      RDATA_O <= bal_pkg::RDATA_RST;
    end
    else
    begin
      if (to_acc)
        acc <= result;
      else if (wr_acc)
        acc <= WDATA_I;
      if (upd_c)
        carry <= new_c;
      else if (wr_st)
        carry <= WDATA_I[bal_pkg::ST_C];
      if (upd_dc)
        nib <= nib_sum[4];
      else if (wr_st)
        nib <= WDATA_I[bal_pkg::ST_NIB];
      if (upd_z)
        zero <= new_z;
      else if (wr_st)
        zero <= WDATA_I[bal_pkg::ST_Z];
      RDATA_O <= RD_I ? rd_mux : 8'h00;
    end
  end

  // Pointers; byte writes from the bus lose to a pointer-add
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      ptr[0] <= bal_pkg::PTR_RST;
      ptr[1] <= bal_pkg::PTR_RST;
    end
    else
    begin
      if (ptr0_upd)
        ptr[0] <= ptr_sum;
      else if (wr_p0l)
        ptr[0][7:0] <= WDATA_I;
      else if (wr_p0h)
        ptr[0][15:8] <= WDATA_I;
      if (ptr1_upd)
        ptr[1] <= ptr_sum;
      else if (wr_p1l)
        ptr[1][7:0] <= WDATA_I;
      else if (wr_p1h)
        ptr[1][15:8] <= WDATA_I;
    end
  end

  assign ACC_O = acc;
  assign CARRY_O = carry;
  assign NIBBLE_OVERFLOW_FLAG_O = nib;
  assign ZERO_O = zero;
  assign POINTER0_O = ptr[0];
  assign POINTER1_O = ptr[1];

  // Helper counters for the cycle-cost checks
  logic [CW-1:0] busy_len;
  logic [CW-1:0] exp_len;
  logic [CW-1:0] idle_len;
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      busy_len <= '0;
      exp_len <= '0;
      idle_len <= '0;
    end
    else
    begin
      busy_len <= accept ? CW'(1) : (READY_O ? '0 : busy_len + CW'(1));
      if (accept)
        exp_len <= in_clks;
      idle_len <= IDLE_SLOT_O ? idle_len + CW'(1) : '0;
    end
  end

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence s_taken_accept;
    accept && in_taken;
  endsequence
  sequence s_slot_end;
    $fell(IDLE_SLOT_O);
  endsequence

  a_cycle_cost_len: assert property (
    $rose(READY_O) |-> busy_len == exp_len)
    else $error("instruction length differs from its cycle cost");
  a_taken_slot_seen: assert property (
    s_taken_accept |-> ##[1:40] IDLE_SLOT_O)
    else $error("taken instruction gave no idle slot");
  a_idle_slot_len: assert property (
    s_slot_end |-> idle_len == CW'(CYCLE_CLKS) && READY_O)
    else $error("idle slot is not one instruction cycle");
  a_ptr_add_flags: assert property (
    exec && is_ptr_add && !WR_I |=> $stable({carry, nib, zero}))
    else $error("pointer add changed a flag");
  a_ptr_add_wrap: assert property (
    exec && is_ptr_add && !psel |=>
    ptr[0] == 16'($past(ptr[0]) + $past(sext)))
    else $error("pointer 0 sum wrong");
  a_imm_add_acc: assert property (
    exec && is_add_imm |=> acc == 8'($past(acc) + $past(lit)))
    else $error("immediate add result wrong");
  a_file_add_wb: assert property (
    exec && is_add_file && dest |->
    mem_if.wr_en && mem_if.wr_data == 8'(acc + fval) && mem_if.wr_addr == ea)
    else $error("file add write-back wrong");
  a_dest_acc_sel: assert property (
    exec && is_file && !dest |-> !mem_if.wr_en ##1 acc == $past(result))
    else $error("destination 0 did not reach accumulator");
  a_addc_sum: assert property (
    exec && is_addc && !dest |=> {carry, acc} ==
    9'($past({1'b0, acc}) + $past({1'b0, fval}) + $past({8'h00, carry})))
    else $error("add with carry wrong");
  a_and_zero_only: assert property (
    exec && is_and_any && !WR_I |=> $stable(carry) && $stable(nib) &&
    zero == ($past(and_res) == 8'h00))
    else $error("and touched the wrong flags");
  a_asr_carry: assert property (
    exec && is_asr && !dest |=> carry == $past(fval[0]) &&
    acc[7:6] == {2{$past(fval[7])}})
    else $error("shift right wrong");
  a_ptr_decode: assert property (
    accept && INSTR_I[13:7] == bal_pkg::OP_PTR_ADD && !in_taken |=>
    is_ptr_add && exec && cnt == CW'(CYCLE_CLKS - 1))
    else $error("pointer add not decoded");
  a_nibble_carry: assert property (
    exec && is_add_any |=>
    nib == (5'($past(acc[3:0])) + 5'($past(add_b[3:0])) +
    5'($past(cin)) > 5'h0f))
    else $error("digit carry wrong");

endmodule

/* File: bal_pkg.sv */
// Shared constants and types for the byte ALU datapath
package bal_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned PTR_W = 16;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned LIT_W = 6;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned CYCLE_CLKS_DEF = 2;

  // Opcode prefixes, instruction bits [13:8]
  localparam logic [5:0] OP_ADD_IMM = 6'h3e;
  localparam logic [5:0] OP_AND_IMM = 6'h39;
  localparam logic [5:0] OP_ADD_FILE = 6'h07;
  localparam logic [5:0] OP_ADDC_FILE = 6'h3d;
  localparam logic [5:0] OP_AND_FILE = 6'h05;
  localparam logic [5:0] OP_ASR_FILE = 6'h37;
  // Pointer-add prefix, instruction bits [13:7]
  localparam logic [6:0] OP_PTR_ADD = 7'h62;

  // Field positions inside the instruction word
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned PTR_SEL_BIT = 6;
  localparam int unsigned LIT_SIGN_BIT = 5;

  // File addresses that act as indirect access ports
  localparam logic [6:0] IND_PORT0 = 7'h00;
  localparam logic [6:0] IND_PORT1 = 7'h01;

  // Status field positions
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_NIB = 1;
  localparam int unsigned ST_Z = 2;
  // Core state field positions
  localparam int unsigned CS_READY = 0;
  localparam int unsigned CS_IDLE = 1;

  // Register offsets
  localparam logic [7:0] REG_ACC = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_PTR0_LO = 8'h02;
  localparam logic [7:0] REG_PTR0_HI = 8'h03;
  localparam logic [7:0] REG_PTR1_LO = 8'h04;
  localparam logic [7:0] REG_PTR1_HI = 8'h05;
  localparam logic [7:0] REG_CORE = 8'h06;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [7:0] RDATA_RST = 8'h00;

  typedef enum logic [1:0] {ST_READY, ST_EXEC, ST_WAIT} bal_state_t;

endpackage

/* File: bal_fr_mem_if.sv */
// Connection between the datapath and its file register memory
`timescale 1ns/1ps
interface bal_fr_mem_if;
  logic wr_en;
  logic [bal_pkg::ADDR_W-1:0] wr_addr;
  logic [bal_pkg::DATA_W-1:0] wr_data;
  logic [bal_pkg::ADDR_W-1:0] rd_addr;
  logic [bal_pkg::DATA_W-1:0] rd_data;
  modport core (output wr_en, output wr_addr, output wr_data,
    output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
    input rd_addr, output rd_data);
endinterface

/* File: bal_fr_mem.sv */
// File register memory with registered read data
`timescale 1ns/1ps
module bal_fr_mem #(
  parameter int unsigned DEPTH = bal_pkg::FILE_DEPTH
) (
  input wire logic clk_i,
  bal_fr_mem_if.mem port
);
  logic [bal_pkg::DATA_W-1:0] store [DEPTH];

  // The read taken at acceptance never shares a clock with a write, so no bypass is needed
  always_ff @(posedge clk_i)
  begin
    if (port.wr_en)
    begin
      store[port.wr_addr] <= port.wr_data;
    end
    port.rd_data <= store[port.rd_addr];
  end
endmodule

/* File: byte_alu_add_and_shift_ops_tb.sv */
// Self-checking testbench for the byte ALU datapath
`timescale 1ns/1ps
module byte_alu_add_and_shift_ops_tb;
  // Three clocks per instruction cycle so that off-by-one costs show up
  localparam int unsigned CC = 3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic prog_change = 1'b0;
  logic test_true = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, acc;
  logic carry, nof, zero, ready, idle;
  logic [15:0] ptr0, ptr1, e0, e1;
  wire [15:0] flg = {13'h0, zero, nof, carry};
  int errors = 0;
  int check_count = 0;
  int ncyc, nidle;
  logic [7:0] v;
  logic [10:0] m;
  logic [2:0] st;
  logic [5:0] ops [4] = '{bal_pkg::OP_ADD_FILE, bal_pkg::OP_ADDC_FILE,
    bal_pkg::OP_AND_FILE, bal_pkg::OP_ASR_FILE};
  logic [5:0] lits [3] = '{6'h1f, 6'h20, 6'h3f};

  bal_core #(.CYCLE_CLKS(CC)) u_bal_core (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .INSTR_VALID_I(instr_valid),
    .INSTR_I(instr), .PROGRAM_COUNTER_CHANGE_I(prog_change),
    .TEST_TRUE_I(test_true),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .ACC_O(acc), .CARRY_O(carry),
    .NIBBLE_OVERFLOW_FLAG_O(nof), .ZERO_O(zero), .POINTER0_O(ptr0),
    .POINTER1_O(ptr1), .READY_O(ready), .IDLE_SLOT_O(idle));

  initial
  begin
    forever #4 clk = ~clk;
  end

  // Reference result: {Z, nibble, C, result}; untouched flags pass through
  function automatic logic [10:0] model(input logic [5:0] op,
    input logic [7:0] a, input logic [7:0] b, input logic [2:0] s);
    logic ci;
    logic [8:0] sum;
    logic [4:0] h;
    logic [7:0] r;
    logic [2:0] n;
    ci = (op == bal_pkg::OP_ADDC_FILE) ? s[0] : 1'b0;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    n = s;
    r = sum[7:0];
    if (op == bal_pkg::OP_AND_FILE || op == bal_pkg::OP_AND_IMM)
      r = a & b;
    else if (op == bal_pkg::OP_ASR_FILE)
    begin
      r = {b[7], b[7:1]};
      n[0] = b[0];
    end
    else
    begin
      n[0] = sum[8];
      n[1] = h[4];
    end
    n[2] = (r == 8'h00);
    return {n, r};
  endfunction

  task automatic chk(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", {8'h00, rdata}, {8'h00, exp});
    @(posedge clk);
    #1;
    chk("rdata idle", {8'h00, rdata}, 16'h0000);
  endtask

  // Issues one instruction and counts clocks until ready returns
  task automatic exec(input logic [13:0] i, input logic p, input logic t);
    @(posedge clk);
    instr <= i;
    instr_valid <= 1'b1;
    prog_change <= p;
    test_true <= t;
    @(posedge clk);
    instr_valid <= 1'b0;
    prog_change <= 1'b0;
    test_true <= 1'b0;
    ncyc = 0;
    nidle = 0;
    forever
    begin
      #1;
      ncyc++;
      if (idle === 1'b1)
        nidle++;
      if (ready === 1'b1 || ncyc > 40)
        break;
      @(posedge clk);
    end
    if (ncyc > 40)
      errors++;
  endtask

  // File memory is not reset: AND with a zero accumulator clears it first
  task automatic set_file(input logic [6:0] a, input logic [7:0] d);
    bus_wr(bal_pkg::REG_ACC, 8'h00);
    exec({bal_pkg::OP_AND_FILE, 1'b1, a}, 1'b0, 1'b0);
    bus_wr(bal_pkg::REG_ACC, d);
    exec({bal_pkg::OP_ADD_FILE, 1'b1, a}, 1'b0, 1'b0);
  endtask

  task automatic get_file(input logic [6:0] a, output logic [7:0] d);
    bus_wr(bal_pkg::REG_ACC, 8'h00);
    exec({bal_pkg::OP_ADD_FILE, 1'b0, a}, 1'b0, 1'b0);
    d = acc;
  endtask

  task automatic report_and_stop;
    $display("Checks made %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    bus_rd(bal_pkg::REG_ACC, 8'h00);
    bus_rd(bal_pkg::REG_STATUS, 8'h00);
    bus_rd(bal_pkg::REG_PTR1_HI, 8'h00);
    bus_wr(bal_pkg::REG_CORE, 8'hfe);
    bus_rd(bal_pkg::REG_CORE, 8'h01);
    bus_rd(8'h07, 8'h00);
    // Immediate add and AND, with nibble and byte carry boundaries
    for (int j = 0; j < 6; j++)
    begin
      v = (j < 4) ? 8'h0f << (j % 3) : 8'hf0;
      m = model(j < 4 ? bal_pkg::OP_ADD_IMM : bal_pkg::OP_AND_IMM, v,
        8'h0f + 8'(j * 8'h78), 3'b011);
      bus_wr(bal_pkg::REG_ACC, v);
      bus_wr(bal_pkg::REG_STATUS, 8'h03);
      exec({j < 4 ? bal_pkg::OP_ADD_IMM : bal_pkg::OP_AND_IMM,
        8'h0f + 8'(j * 8'h78)}, 1'b0, 1'b0);
      chk("imm acc", {8'h00, acc}, {8'h00, m[7:0]});
      chk("imm flags", flg, {13'h0, m[10:8]});
    end
    // File ops, both destinations, address range top end
    for (int i = 0; i < 8; i++)
    begin
      st = i[0] ? 3'b011 : 3'b000;
      set_file(7'h78 + 7'(i), 8'heb);
      bus_wr(bal_pkg::REG_ACC, 8'h9c);
      bus_wr(bal_pkg::REG_STATUS, {5'h00, st});
      m = model(ops[i / 2], 8'h9c, 8'heb, st);
      exec({ops[i / 2], i[0], 7'h78 + 7'(i)}, 1'b0, 1'b0);
      chk("file acc", {8'h00, acc}, {8'h00, i[0] ? 8'h9c : m[7:0]});
      chk("file flg", flg, 16'(m[10:8]));
      bus_rd(bal_pkg::REG_STATUS, {5'h00, m[10:8]});
      get_file(7'h78 + 7'(i), v);
      chk("file mem", {8'h00, v}, {8'h00, i[0] ? m[7:0] : 8'heb});
    end
    // Pointer add with wrap both ways, flags left alone
    bus_wr(bal_pkg::REG_PTR0_LO, 8'hf0);
    bus_wr(bal_pkg::REG_PTR0_HI, 8'hff);
    bus_wr(bal_pkg::REG_PTR1_LO, 8'h05);
    bus_wr(bal_pkg::REG_STATUS, 8'h07);
    e0 = 16'hfff0;
    e1 = 16'h0005;
    for (int i = 0; i < 3; i++)
    begin
      if (i == 1)
        e1 = e1 + {{10{lits[i][5]}}, lits[i]};
      else
        e0 = e0 + {{10{lits[i][5]}}, lits[i]};
      exec({bal_pkg::OP_PTR_ADD, i == 1, lits[i]}, 1'b0, 1'b0);
      chk("ptr0", ptr0, e0);
      chk("ptr1", ptr1, e1);
      chk("ptr flags", flg, 16'h0007);
      chk("ptr cycles", 16'(ncyc), 16'(CC));
    end
    bus_rd(bal_pkg::REG_PTR1_HI, e1[15:8]);
    // Taken branch or true test costs a second, idle cycle
    for (int j = 0; j < 3; j++)
    begin
      bus_wr(bal_pkg::REG_ACC, 8'h01);
      exec({bal_pkg::OP_ADD_IMM, 8'h01}, j == 1, j == 2);
      chk("taken acc", {8'h00, acc}, 16'h0002);
      chk("taken cycles", 16'(ncyc), 16'((j > 0 ? 2 : 1) * CC));
      chk("idle slot", 16'(nidle), 16'(j > 0 ? CC : 0));
    end
    // Indirect port whose pointer has its top bit set costs one more
    set_file(7'h10, 8'h21);
    bus_wr(bal_pkg::REG_PTR0_LO, 8'h10);
    bus_wr(bal_pkg::REG_PTR0_HI, 8'h80);
    bus_wr(bal_pkg::REG_PTR1_LO, 8'h10);
    bus_wr(bal_pkg::REG_PTR1_HI, 8'h00);
    bus_wr(bal_pkg::REG_ACC, 8'h05);
    for (int j = 0; j < 3; j++)
    begin
      exec({bal_pkg::OP_ADD_FILE, 1'b0, 7'(j / 2)}, j == 1, 1'b0);
      chk("ind acc", {8'h00, acc}, 16'(8'h05 + 8'h21 * (j + 1)));
      chk("ind cycles", 16'(ncyc), 16'((j == 2 ? 1 : j + 2) * CC));
      chk("ind idle", 16'(nidle), 16'(j == 1 ? CC : 0));
    end
    report_and_stop();
  end
endmodule
